/* File: hdl/kwi_detect.sv */
`timescale 1ns/1ps
module kwi_detect (
    input  logic                      clk,
    input  logic                      rst_n,
    input  logic [kwi_pkg::KWI_PINS-1:0] sampled,
    input  logic [kwi_pkg::KWI_PINS-1:0] pin_enable,
    input  logic [kwi_pkg::KWI_PINS-1:0] polarity,
    input  logic                      edge_level_mode,
    input  logic                      stop_mode,
    output logic                      set_flag
);
    import kwi_pkg::*;

    logic [KWI_PINS-1:0] prev;
    logic [KWI_PINS-1:0] now_asserted;
    logic [KWI_PINS-1:0] was_asserted;
    logic [KWI_PINS-1:0] new_edge;
    logic                others_quiet;
    logic                edge_hit;
    logic                level_hit;

    ////////////////////////////////////////////////////////////////////////////
    // The previous sample, one bus cycle older than the current one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= KWI_RST_SYNC;
        end else begin
            prev <= sampled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Asserted level is high for rising polarity and low for falling.
    assign now_asserted = sampled ~^ polarity;
    assign was_asserted = prev ~^ polarity;
    assign new_edge     = pin_enable & now_asserted & ~was_asserted;
    assign others_quiet = ~|(pin_enable & was_asserted);
    assign edge_hit     = edge_level_mode ? (|new_edge & others_quiet)
                                          : |new_edge;
    assign level_hit    = edge_level_mode & |(pin_enable & now_asserted);
    assign set_flag     = ~stop_mode & (edge_hit | level_hit);

endmodule // kwi_detect

/* File: hdl/kwi_pkg.sv */
package kwi_pkg;

    localparam int KWI_PINS = 8;
    localparam int KWI_POL_PINS = 4;

    localparam logic [7:0] KWI_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] KWI_OFS_PIN_ENABLE     = 8'h04;
    localparam logic [7:0] KWI_OFS_EVT_STATUS     = 8'h08;
    localparam logic [7:0] KWI_OFS_EVT_CLEAR      = 8'h0c;
    localparam logic [7:0] KWI_OFS_EVT_ENABLE     = 8'h10;

    localparam int KWI_BIT_MODE    = 0;
    localparam int KWI_BIT_IRQ_EN  = 1;
    localparam int KWI_BIT_ACK     = 2;
    localparam int KWI_BIT_FLAG    = 3;
    localparam int KWI_BIT_POL_LSB = 4;
    localparam int KWI_BIT_POL_MSB = 7;

    localparam int KWI_EVT_W    = 2;
    localparam int KWI_EVT_EDGE = 0;
    localparam int KWI_EVT_WAKE = 1;

    localparam logic [7:0]  KWI_RST_PIN_ENABLE = 8'h00;
    localparam logic [3:0]  KWI_RST_POLARITY   = 4'h0;
    localparam logic [1:0]  KWI_RST_EVT        = 2'h0;
    localparam logic [7:0]  KWI_RST_SYNC       = 8'hff;
    localparam logic [3:0]  KWI_FIXED_POLARITY = 4'h0;
    localparam logic [23:0] KWI_PAD_BITS       = 24'h000000;

    localparam logic [1:0] KWI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] KWI_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [KWI_POL_PINS-1:0] pin_polarity_select;
        logic                    keypad_irq_enable;
        logic                    edge_level_mode;
    } kwi_ctrl_type;

endpackage

/* File: hdl/kwi_sync.sv */
`timescale 1ns/1ps
module kwi_sync #(
    parameter int                    WIDTH     = kwi_pkg::KWI_PINS,
    parameter logic [WIDTH-1:0]      RESET_VAL = kwi_pkg::KWI_RST_SYNC
) (
    input  logic             clk,
    input  logic             rst_n,
    input  logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import kwi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Two flops per bit; the first is read only by the second.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    stage1 <= RESET_VAL[i];
                    stage2 <= RESET_VAL[i];
                end else begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate

endmodule // kwi_sync

/* File: hdl/kwi_top.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module kwi_top #(
    parameter int ADDR_W = 8
) (
    input  logic                         aclk,
    input  logic                         aresetn,
    input  logic [ADDR_W-1:0]            s_axi_awaddr,
    input  logic                         s_axi_awvalid,
    output logic                         s_axi_awready,
    input  logic [31:0]                  s_axi_wdata,
    input  logic [3:0]                   s_axi_wstrb,
    input  logic                         s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  logic                         s_axi_bready,
    input  logic [ADDR_W-1:0]            s_axi_araddr,
    input  logic                         s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  logic                         s_axi_rready,
    input  logic [kwi_pkg::KWI_PINS-1:0] key_pins,
    input  logic                         stop_mode,
    output logic                         wake_request,
    output logic                         irq
);
    import kwi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    kwi_ctrl_type           ctrl;
    logic [KWI_PINS-1:0]    keypad_pin_enable;
    logic                   keypad_event_flag;
    logic [KWI_EVT_W-1:0]   evt_status;
    logic [KWI_EVT_W-1:0]   evt_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Bus state.
    logic                   aw_held;
    logic [ADDR_W-1:0]      aw_addr_q;
    logic                   w_held;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Detection path.
    logic [KWI_PINS-1:0]    key_sampled;
    logic [KWI_PINS-1:0]    full_polarity;
    logic [KWI_PINS-1:0]    raw_asserted;
    logic                   set_flag;
    logic                   next_flag;
    logic [KWI_EVT_W-1:0]   evt_set;
    logic [KWI_EVT_W-1:0]   next_evt_status;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode wires.
    logic                   aw_hs;
    logic                   w_hs;
    logic                   ar_hs;
    logic                   do_write;
    logic                   lane0;
    logic                   wr_sel_sc;
    logic                   wr_sel_pe;
    logic                   wr_sel_es;
    logic                   wr_sel_ec;
    logic                   wr_sel_ee;
    logic                   wr_hit;
    logic                   wr_sc;
    logic                   wr_pe;
    logic                   wr_ec;
    logic                   wr_ee;
    logic                   ack_pulse;
    logic [KWI_EVT_W-1:0]   evt_clear;
    logic                   rd_sel_sc;
    logic                   rd_sel_pe;
    logic                   rd_sel_es;
    logic                   rd_sel_ec;
    logic                   rd_sel_ee;
    logic                   rd_hit;
    logic [7:0]             sc_view;
    logic [31:0]            rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Key inputs are synchronised, then compared with their previous sample.
    kwi_sync #(
        .WIDTH     (KWI_PINS),
        .RESET_VAL (KWI_RST_SYNC)
    ) u_sync (
        .clk      (aclk),
        .rst_n    (aresetn),
        .async_in (key_pins),
        .sync_out (key_sampled)
    );

    assign full_polarity = {ctrl.pin_polarity_select, KWI_FIXED_POLARITY};

    kwi_detect u_detect (
        .clk             (aclk),
        .rst_n           (aresetn),
        .sampled         (key_sampled),
        .pin_enable      (keypad_pin_enable),
        .polarity        (full_polarity),
        .edge_level_mode (ctrl.edge_level_mode),
        .stop_mode       (stop_mode),
        .set_flag        (set_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Stop mode: enabled pins wake the device by level, with no clock involved.
    assign raw_asserted = key_pins ~^ full_polarity;
    assign wake_request = stop_mode & |(keypad_pin_enable & raw_asserted);

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes and write decode.
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign s_axi_arready = ~rvalid;
    assign aw_hs         = s_axi_awvalid & ~aw_held;
    assign w_hs          = s_axi_wvalid & ~w_held;
    assign ar_hs         = s_axi_arvalid & ~rvalid;
    assign do_write      = aw_held & w_held & ~bvalid;
    assign lane0         = w_strb_q[0];

    assign wr_sel_sc = (aw_addr_q == ADDR_W'(KWI_OFS_STATUS_CONTROL));
    assign wr_sel_pe = (aw_addr_q == ADDR_W'(KWI_OFS_PIN_ENABLE));
    assign wr_sel_es = (aw_addr_q == ADDR_W'(KWI_OFS_EVT_STATUS));
    assign wr_sel_ec = (aw_addr_q == ADDR_W'(KWI_OFS_EVT_CLEAR));
    assign wr_sel_ee = (aw_addr_q == ADDR_W'(KWI_OFS_EVT_ENABLE));
    assign wr_hit    = wr_sel_sc | wr_sel_pe | wr_sel_es | wr_sel_ec | wr_sel_ee;

    assign wr_sc     = do_write & wr_sel_sc & lane0;
    assign wr_pe     = do_write & wr_sel_pe & lane0;
    assign wr_ec     = do_write & wr_sel_ec & lane0;
    assign wr_ee     = do_write & wr_sel_ee & lane0;
    assign ack_pulse = wr_sc & w_data_q[KWI_BIT_ACK];
    assign evt_clear = wr_ec ? w_data_q[KWI_EVT_W-1:0] : KWI_RST_EVT;

    ////////////////////////////////////////////////////////////////////////////
    // Flag and event status; a set in the clearing cycle wins.
    assign next_flag = set_flag | (keypad_event_flag & ~ack_pulse);
    assign evt_set[KWI_EVT_EDGE] = set_flag & ~keypad_event_flag;
    assign evt_set[KWI_EVT_WAKE] = wake_request;
    assign next_evt_status       = evt_set | (evt_status & ~evt_clear);

    assign irq = (ctrl.keypad_irq_enable & keypad_event_flag)
               | (|(evt_status & evt_enable));

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; acknowledge reads 0 and the flag reflects the live state.
    assign sc_view = {ctrl.pin_polarity_select, keypad_event_flag, 1'b0,
                      ctrl.keypad_irq_enable, ctrl.edge_level_mode};

    assign rd_sel_sc = (s_axi_araddr == ADDR_W'(KWI_OFS_STATUS_CONTROL));
    assign rd_sel_pe = (s_axi_araddr == ADDR_W'(KWI_OFS_PIN_ENABLE));
    assign rd_sel_es = (s_axi_araddr == ADDR_W'(KWI_OFS_EVT_STATUS));
    assign rd_sel_ec = (s_axi_araddr == ADDR_W'(KWI_OFS_EVT_CLEAR));
    assign rd_sel_ee = (s_axi_araddr == ADDR_W'(KWI_OFS_EVT_ENABLE));
    assign rd_hit    = rd_sel_sc | rd_sel_pe | rd_sel_es | rd_sel_ec | rd_sel_ee;

    assign rd_word = rd_sel_sc ? {KWI_PAD_BITS, sc_view} :
                     rd_sel_pe ? {KWI_PAD_BITS, keypad_pin_enable} :
                     rd_sel_es ? {30'h0, evt_status} :
                     rd_sel_ee ? {30'h0, evt_enable} :
                                 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Write address and data are held until both are present.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (aw_hs) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held   <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held   <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (w_hs) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= KWI_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? KWI_RESP_OKAY : KWI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;

    ////////////////////////////////////////////////////////////////////////////
    // Read response, registered one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= KWI_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? KWI_RESP_OKAY : KWI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata  = rdata;
    assign s_axi_rresp  = rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; the flag bit is never written by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl.pin_polarity_select <= KWI_RST_POLARITY;
            ctrl.keypad_irq_enable   <= 1'b0;
            ctrl.edge_level_mode     <= 1'b0;
        end else if (wr_sc) begin
            ctrl.pin_polarity_select <= w_data_q[KWI_BIT_POL_MSB:KWI_BIT_POL_LSB];
            ctrl.keypad_irq_enable   <= w_data_q[KWI_BIT_IRQ_EN];
            ctrl.edge_level_mode     <= w_data_q[KWI_BIT_MODE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keypad_pin_enable <= KWI_RST_PIN_ENABLE;
        end else if (wr_pe) begin
            keypad_pin_enable <= w_data_q[KWI_PINS-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_enable <= KWI_RST_EVT;
        end else if (wr_ee) begin
            evt_enable <= w_data_q[KWI_EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag and sticky event bits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keypad_event_flag <= 1'b0;
            evt_status        <= KWI_RST_EVT;
        end else begin
            keypad_event_flag <= next_flag;
            evt_status        <= next_evt_status;
        end
    end

endmodule // kwi_top

/* File: verification/kwi_assertions.sv */
`timescale 1ns/1ps
module kwi_assertions #(
    parameter int ADDR_W = 8
) (
    input logic              aclk,
    input logic              aresetn,
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic              s_axi_awvalid,
    input logic              s_axi_awready,
    input logic [31:0]       s_axi_wdata,
    input logic [3:0]        s_axi_wstrb,
    input logic              s_axi_wvalid,
    input logic              s_axi_wready,
    input logic [1:0]        s_axi_bresp,
    input logic              s_axi_bvalid,
    input logic              s_axi_bready,
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic              s_axi_arvalid,
    input logic              s_axi_arready,
    input logic [31:0]       s_axi_rdata,
    input logic [1:0]        s_axi_rresp,
    input logic              s_axi_rvalid,
    input logic              s_axi_rready,
    input logic [7:0]        key_pins,
    input logic              stop_mode,
    input logic              wake_request,
    input logic              irq
);
    import kwi_pkg::*;
    logic [7:0]        key_q;
    logic [3:0]        since_key;
    logic [ADDR_W-1:0] ar_q;
    always_ff @(posedge aclk) begin
        key_q <= key_pins;
        if (!aresetn) since_key <= 4'hf;
        else if (key_pins != key_q) since_key <= 4'h0;
        else if (since_key != 4'hf) since_key <= since_key + 4'h1;
    end
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_w_take; s_axi_wvalid && s_axi_wready; endsequence
    sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
    a_write_answer: assert property ((s_aw_take and s_w_take) ##0 !s_axi_bvalid |->
        ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read response late");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_ack_reads_zero: assert property (s_axi_rvalid && ar_q == KWI_OFS_STATUS_CONTROL |->
        !s_axi_rdata[KWI_BIT_ACK] && s_axi_rdata[31:8] == 24'h0)
        else $error("acknowledge bit read back set");
    a_unmapped_err: assert property (s_axi_rvalid && ar_q > KWI_OFS_EVT_ENABLE |->
        s_axi_rresp == KWI_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_wake_in_stop: assert property (!stop_mode |-> !wake_request)
        else $error("wake request outside stop");
    a_irq_edge_delay: assert property ($rose(irq) &&
        !$rose(s_axi_bvalid) && !stop_mode |-> since_key == 4'h2)
        else $error("interrupt not tied to a synchronised key edge");
    a_irq_fall_ack: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without a register write");
endmodule // kwi_assertions
bind kwi_top kwi_assertions #(.ADDR_W(ADDR_W)) kwi_assertions_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .key_pins(key_pins), .stop_mode(stop_mode),
    .wake_request(wake_request), .irq(irq));

/* File: verification/kwi_keypad.sv */
`timescale 1ns/1ps
module kwi_keypad (
    input  logic [7:0] pressed,
    input  logic [7:0] rise_sel,
    output logic [7:0] key_pins
);
    // A pressed key drives its asserted level; a free line rests at its pull level.
    assign key_pins = rise_sel ^ ~pressed;
endmodule // kwi_keypad

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import kwi_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, stop_mode, wake_request, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, pressed, rise_sel, key_pins, m;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          bad_count, comparisons, p;
    kwi_top kwi_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_pins(key_pins),
        .stop_mode(stop_mode), .wake_request(wake_request), .irq(irq));
    kwi_keypad kwi_keypad_inst (.pressed(pressed), .rise_sel(rise_sel), .key_pins(key_pins));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////
    task stop_test;
        $display("counts: %0d compares, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cy(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task chk_irq(input logic e);
        #1;
        cmp({33'h0, irq}, {33'h0, e});
    endtask
    task key(input logic [7:0] v);
        @(posedge aclk);
        pressed <= v;
    endtask
    task resp_wait(input bit rd_sel);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (n < 50 && (rd_sel ? s_axi_rvalid : s_axi_bvalid) !== 1'b1);
        if (n >= 50) begin
            bad_count++;
            stop_test;
        end
        @(posedge aclk);
        if (rd_sel) s_axi_rready <= 1'b1;
        else s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        s_axi_bready <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic pa, pw;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        for (n = 0; (pa || pw) && n < 50; n++) begin
            @(negedge aclk);
            if (s_axi_awready === 1'b1) pa = 1'b0;
            if (s_axi_wready === 1'b1) pw = 1'b0;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        if (pa || pw) begin
            bad_count++;
            stop_test;
        end
        resp_wait(1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic pa;
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        pa = 1'b1;
        for (n = 0; pa && n < 50; n++) begin
            @(negedge aclk);
            if (s_axi_arready === 1'b1) pa = 1'b0;
            @(posedge aclk);
            s_axi_arvalid <= pa;
        end
        if (pa) begin
            bad_count++;
            stop_test;
        end
        resp_wait(1'b1);
    endtask
    always @(negedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            cmp({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        end
    end
    initial begin
        repeat (100000) @(posedge aclk);
        bad_count++;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, stop_mode, s_axi_awaddr, s_axi_araddr} = 18'h00000;
        {s_axi_wdata, pressed, rise_sel} = 48'h0;
        s_axi_wstrb = 4'hf;
        p = $urandom(75152);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(KWI_OFS_STATUS_CONTROL, 32'h0, KWI_RESP_OKAY);
        rd(KWI_OFS_PIN_ENABLE, 32'h0, KWI_RESP_OKAY);
        rd(KWI_OFS_EVT_STATUS, 32'h0, KWI_RESP_OKAY);
        chk_irq(1'b0);
        wr(KWI_OFS_STATUS_CONTROL, 32'hff, KWI_RESP_OKAY);
        rd(KWI_OFS_STATUS_CONTROL, 32'hf3, KWI_RESP_OKAY);
        wr(8'h14, 32'h1, KWI_RESP_SLVERR);
        rd(8'h14, 32'h0, KWI_RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(KWI_OFS_PIN_ENABLE, 32'hff, KWI_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(KWI_OFS_PIN_ENABLE, 32'h00, KWI_RESP_OKAY);
        $display("test registers done");
        wr(KWI_OFS_STATUS_CONTROL, 32'h02, KWI_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            p = $urandom_range(3, 0);
            m = 8'($urandom) | (8'h01 << p);
            wr(KWI_OFS_PIN_ENABLE, {24'h0, m & ~(8'h01 << p)}, KWI_RESP_OKAY);
            key(8'h01 << p);
            cy(5);
            chk_irq(1'b0);
            key(8'h00);
            wr(KWI_OFS_PIN_ENABLE, {24'h0, m}, KWI_RESP_OKAY);
            rd(KWI_OFS_PIN_ENABLE, {24'h0, m}, KWI_RESP_OKAY);
            key(8'h01 << p);
            cy(4);
            chk_irq(1'b1);
            rd(KWI_OFS_STATUS_CONTROL, 32'h0a, KWI_RESP_OKAY);
            key(8'h00);
            cy(4);
            chk_irq(1'b1);
            wr(KWI_OFS_STATUS_CONTROL, 32'h06, KWI_RESP_OKAY);
            cy(1);
            chk_irq(1'b0);
        end
        $display("test pin enables done");
        wr(KWI_OFS_STATUS_CONTROL, 32'h00, KWI_RESP_OKAY);
        wr(KWI_OFS_PIN_ENABLE, 32'h01, KWI_RESP_OKAY);
        key(8'h01);
        cy(4);
        chk_irq(1'b0);
        wr(KWI_OFS_STATUS_CONTROL, 32'h00, KWI_RESP_OKAY);
        rd(KWI_OFS_STATUS_CONTROL, 32'h08, KWI_RESP_OKAY);
        key(8'h00);
        wr(KWI_OFS_STATUS_CONTROL, 32'h04, KWI_RESP_OKAY);
        rd(KWI_OFS_STATUS_CONTROL, 32'h00, KWI_RESP_OKAY);
        $display("test polling done");
        wr(KWI_OFS_STATUS_CONTROL, 32'hf2, KWI_RESP_OKAY);
        @(posedge aclk);
        rise_sel <= 8'hf0;
        wr(KWI_OFS_PIN_ENABLE, 32'h10, KWI_RESP_OKAY);
        key(8'h10);
        cy(4);
        chk_irq(1'b1);
        key(8'h00);
        wr(KWI_OFS_STATUS_CONTROL, 32'hf6, KWI_RESP_OKAY);
        wr(KWI_OFS_PIN_ENABLE, 32'h01, KWI_RESP_OKAY);
        key(8'h01);
        cy(4);
        chk_irq(1'b1);
        key(8'h00);
        rise_sel <= 8'h00;
        wr(KWI_OFS_STATUS_CONTROL, 32'h07, KWI_RESP_OKAY);
        $display("test polarity done");
        key(8'h01);
        cy(4);
        chk_irq(1'b1);
        wr(KWI_OFS_STATUS_CONTROL, 32'h07, KWI_RESP_OKAY);
        cy(1);
        chk_irq(1'b1);
        rd(KWI_OFS_STATUS_CONTROL, 32'h0b, KWI_RESP_OKAY);
        key(8'h00);
        cy(4);
        wr(KWI_OFS_STATUS_CONTROL, 32'h07, KWI_RESP_OKAY);
        cy(1);
        chk_irq(1'b0);
        $display("test level mode done");
        wr(KWI_OFS_STATUS_CONTROL, 32'h02, KWI_RESP_OKAY);
        @(posedge aclk);
        stop_mode <= 1'b1;
        key(8'h01);
        cy(1);
        cmp({33'h0, wake_request}, 34'h1);
        cy(4);
        chk_irq(1'b0);
        key(8'h00);
        cy(1);
        cmp({33'h0, wake_request}, 34'h0);
        @(posedge aclk);
        stop_mode <= 1'b0;
        wr(KWI_OFS_EVT_ENABLE, 32'h02, KWI_RESP_OKAY);
        cy(1);
        chk_irq(1'b1);
        rd(KWI_OFS_EVT_STATUS, 32'h03, KWI_RESP_OKAY);
        wr(KWI_OFS_EVT_CLEAR, 32'h03, KWI_RESP_OKAY);
        cy(1);
        chk_irq(1'b0);
        rd(KWI_OFS_EVT_STATUS, 32'h00, KWI_RESP_OKAY);
        rd(KWI_OFS_EVT_CLEAR, 32'h00, KWI_RESP_OKAY);
        rd(KWI_OFS_EVT_ENABLE, 32'h02, KWI_RESP_OKAY);
        $display("test stop mode done");
        stop_test;
    end
endmodule // tb_top
